// *** hdl/tef_pkg.sv ***
// Purpose: shared constants and carriers for the timer event / reference block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package tef_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] TEF_OFF_MODE    = 8'h00; // timer_mode_reg
  localparam logic [7:0] TEF_OFF_XMODE   = 8'h04; // timer_extended_mode_reg
  localparam logic [7:0] TEF_OFF_EVENT   = 8'h08; // timer_event_flags
  localparam logic [7:0] TEF_OFF_COMPARE = 8'h0C; // compare_value_reg
  localparam logic [7:0] TEF_OFF_LATCHED = 8'h10; // latched_count_reg
  localparam logic [7:0] TEF_OFF_COUNT   = 8'h14; // count_value_reg
  localparam logic [7:0] TEF_OFF_IRQ_ST  = 8'h18; // sticky status, read clears
  localparam logic [7:0] TEF_OFF_IRQ_MSK = 8'h1C; // interrupt mask

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int TEF_BIT_CAP      = 0; // event: capture_occurred_flag
  localparam int TEF_BIT_REF      = 1; // event: reference reached
  localparam int TEF_BIT_ENABLE   = 0; // mode: timer run
  localparam int TEF_BIT_RESTART  = 3; // mode: restart_on_match
  localparam int TEF_BIT_REQ_EN   = 4; // mode: reference_request_enable
  localparam int TEF_POS_EDGE     = 6; // mode: capture edge, two bits
  localparam int TEF_POS_PS       = 8; // mode: prescale, upper byte
  localparam int TEF_BIT_DMA_SEL  = 7; // xmode: dma_request_select
  localparam int TEF_EVENT_W      = 2; // implemented event bits

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] TEF_RST_MODE    = 16'h0000;
  localparam logic [7:0]  TEF_RST_XMODE   = 8'h00;
  localparam logic [31:0] TEF_RST_COMPARE = 32'hFFFF_FFFF;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    TEF_EDGE_OFF,
    TEF_EDGE_RISE,
    TEF_EDGE_FALL,
    TEF_EDGE_ANY
  } tef_edge_e;

  typedef enum logic [1:0] {
    TEF_RESP_OKAY   = 2'b00,
    TEF_RESP_SLVERR = 2'b10
  } tef_resp_e;

  typedef struct packed {
    logic      restart;   // restart_on_match
    logic      req_en;    // reference_request_enable
    logic      dma_sel;   // dma_request_select
    tef_edge_e edge_sel;
  } tef_cfg_s;

  typedef struct packed {
    logic irq;
    logic dma;
  } tef_req_s;

endpackage : tef_pkg

// *** hdl/tef_route.sv ***
// Purpose: steer reference and capture flags onto interrupt or dma requests
// Assumes: flags and configuration on the same clock
// Notes:   combinational request choice, registered by the caller
`timescale 1ns/1ps
module tef_route
  import tef_pkg::*;
(
  // configuration and flags
  input  wire tef_cfg_s cfg,
  input  wire logic     ref_flag,
  input  wire logic     cap_flag,
  // request choice
  output tef_req_s      req
);

  logic ref_want;
  logic cap_want;

  // reference asks only when enabled, capture only when an edge is selected
  assign ref_want = ref_flag && cfg.req_en;
  assign cap_want = cap_flag && (cfg.edge_sel != TEF_EDGE_OFF);

  // dma select decides which request line carries the event
  assign req.irq = (ref_want || cap_want) && !cfg.dma_sel;
  assign req.dma = (ref_want || cap_want) && cfg.dma_sel;

endmodule : tef_route

// *** hdl/tef_timer.sv ***
// Purpose: event flags, reference compare and request steering of one timer channel
// Assumes: AXI4-Lite slave on ref_clk, timer input from a pin, dma ack on ref_clk
// Notes:   counter runs from a prescaled ref_clk; dma ack clears both flags
//
// Functional notes
// - flags set on events regardless of request enables; edge setting gates capture events
// - writing one clears a flag, zero leaves it; each flag clears on its own
// - interrupt request held while an enabled flag stays set and dma select is clear
// - dma acknowledge clears both reference and capture flags
// - reference flag on match; enable and dma select choose request kind
// - capture flag on latch; edge 00 no request, else irq or dma
// - match only when count equals compare and prescaler ticks
// - edge setting: off, rising, falling, any edge of timer input
// - restart mode clears counter on match; free run keeps counting
`timescale 1ns/1ps
module tef_timer
  import tef_pkg::*;
#(
  parameter int PS_W = 8  // prescaler width
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // timer input pin and dma handshake
  input  wire logic        timer_in,
  input  wire logic        dma_ack,
  // requests
  output logic             irq_req,
  output logic             dma_req,
  output logic             irq
);

  // ************************************************************
  // elaboration check
  // ************************************************************
  // the prescale field ends at bit 15 of the mode register
  if (PS_W < 1 || PS_W > 16 - TEF_POS_PS) begin : g_bad_ps
    $error("PS_W must be 1..8");
  end

  // ************************************************************
  // registers and state
  // ************************************************************
  logic [15:0]            mode_q;
  logic [7:0]             xmode_q;
  logic [31:0]            compare_q;
  logic [31:0]            count_q;
  logic [31:0]            latched_q;
  logic [TEF_EVENT_W-1:0] event_q;
  logic [TEF_EVENT_W-1:0] sticky_q;
  logic [TEF_EVENT_W-1:0] mask_q;
  logic [PS_W-1:0]        presc_q;
  logic [2:0]             pin_q;
  logic                   pin_lvl_q;
  logic                   aw_hold_q;
  logic                   w_hold_q;
  logic [7:0]             aw_addr_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;

  tef_cfg_s               cfg;
  tef_req_s               route;
  logic                   tick;
  logic                   match;
  logic                   rise;
  logic                   fall;
  logic                   cap_evt;
  logic                   wr_go;
  logic                   rd_go;
  logic [TEF_EVENT_W-1:0] w1c;
  logic [TEF_EVENT_W-1:0] rd_clr;
  logic [TEF_EVENT_W-1:0] evt_set;

  assign cfg.restart  = mode_q[TEF_BIT_RESTART];
  assign cfg.req_en   = mode_q[TEF_BIT_REQ_EN];
  assign cfg.dma_sel  = xmode_q[TEF_BIT_DMA_SEL];
  assign cfg.edge_sel = tef_edge_e'(mode_q[TEF_POS_EDGE +: 2]);

  // ************************************************************
  // bus write path
  // ************************************************************
  // address and data may arrive in either order; each is held until both
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= TEF_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready;
      s_axi_wready  <= !w_hold_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q > TEF_OFF_IRQ_MSK || aw_addr_q[1:0] != 2'b00)
                        ? TEF_RESP_SLVERR : TEF_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; byte strobes honoured
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q    <= TEF_RST_MODE;
      xmode_q   <= TEF_RST_XMODE;
      compare_q <= TEF_RST_COMPARE;
      mask_q    <= '0;
    end else if (wr_go) begin
      if (aw_addr_q == TEF_OFF_MODE) begin
        if (w_strb_q[0]) mode_q[7:0]  <= w_data_q[7:0];
        if (w_strb_q[1]) mode_q[15:8] <= w_data_q[15:8];
      end else if (aw_addr_q == TEF_OFF_XMODE) begin
        if (w_strb_q[0]) xmode_q <= w_data_q[7:0];
      end else if (aw_addr_q == TEF_OFF_COMPARE) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_q[b]) compare_q[8*b +: 8] <= w_data_q[8*b +: 8];
        end
      end else if (aw_addr_q == TEF_OFF_IRQ_MSK) begin
        if (w_strb_q[0]) mask_q <= w_data_q[TEF_EVENT_W-1:0];
      end
    end
  end

  // ************************************************************
  // prescaler, counter and reference compare
  // ************************************************************
  assign tick  = mode_q[TEF_BIT_ENABLE] && (presc_q == mode_q[TEF_POS_PS +: PS_W]);
  assign match = tick && (count_q == compare_q);

  always_ff @(posedge ref_clk) begin
    if (rst || !mode_q[TEF_BIT_ENABLE]) begin
      presc_q <= '0;
    end else begin
      presc_q <= tick ? '0 : presc_q + 1'b1;
    end
  end

  // a write to the count register clears it, whatever the data
  always_ff @(posedge ref_clk) begin
    if (rst || !mode_q[TEF_BIT_ENABLE]) begin
      count_q <= 32'h0000_0000;
    end else if (wr_go && aw_addr_q == TEF_OFF_COUNT) begin
      count_q <= 32'h0000_0000;
    end else if (match && cfg.restart) begin
      count_q <= 32'h0000_0000;
    end else if (tick) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // ************************************************************
  // capture input
  // ************************************************************
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_q     <= 3'b000;
      pin_lvl_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[1:0], timer_in};
      if (pin_q[1] == pin_q[2]) pin_lvl_q <= pin_q[2];
    end
  end

  assign rise    = (pin_q[1] == pin_q[2]) && pin_q[2] && !pin_lvl_q;
  assign fall    = (pin_q[1] == pin_q[2]) && !pin_q[2] && pin_lvl_q;
  // edge selection decides which transitions latch the count
  assign cap_evt = mode_q[TEF_BIT_ENABLE] &&
                   ((cfg.edge_sel == TEF_EDGE_RISE && rise) ||
                    (cfg.edge_sel == TEF_EDGE_FALL && fall) ||
                    (cfg.edge_sel == TEF_EDGE_ANY && (rise || fall)));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latched_q <= 32'h0000_0000;
    end else if (cap_evt) begin
      latched_q <= count_q;
    end
  end

  // ************************************************************
  // event flags
  // ************************************************************
  assign evt_set = {match, cap_evt};
  // only the two low bits exist, so upper data bits never land
  assign w1c = (wr_go && aw_addr_q == TEF_OFF_EVENT && w_strb_q[0])
               ? w_data_q[TEF_EVENT_W-1:0] : '0;
  assign rd_clr = (rd_go && s_axi_araddr == TEF_OFF_IRQ_ST) ? sticky_q : '0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      event_q <= '0;
    end else if (dma_ack) begin
      event_q <= evt_set;
    end else begin
      event_q <= (event_q & ~w1c) | evt_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sticky_q <= '0;
    end else begin
      sticky_q <= (sticky_q & ~rd_clr) | evt_set;
    end
  end

  tef_route u_route (
    .cfg      (cfg),
    .ref_flag (event_q[TEF_BIT_REF]),
    .cap_flag (event_q[TEF_BIT_CAP]),
    .req      (route)
  );

  // irq_req and dma_req follow the flags, one cycle behind; irq follows the masked sticky status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_req <= 1'b0;
      dma_req <= 1'b0;
      irq     <= 1'b0;
    end else begin
      irq_req <= route.irq;
      dma_req <= route.dma;
      irq     <= |(((sticky_q & ~rd_clr) | evt_set) & mask_q);
    end
  end

  // ************************************************************
  // bus read path
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TEF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= TEF_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == TEF_OFF_MODE) begin
          s_axi_rdata <= {16'h0000, mode_q};
        end else if (s_axi_araddr == TEF_OFF_XMODE) begin
          s_axi_rdata <= {24'h00_0000, xmode_q};
        end else if (s_axi_araddr == TEF_OFF_EVENT) begin
          s_axi_rdata <= {30'h0000_0000, event_q};
        end else if (s_axi_araddr == TEF_OFF_COMPARE) begin
          s_axi_rdata <= compare_q;
        end else if (s_axi_araddr == TEF_OFF_LATCHED) begin
          s_axi_rdata <= latched_q;
        end else if (s_axi_araddr == TEF_OFF_COUNT) begin
          s_axi_rdata <= count_q;
        end else if (s_axi_araddr == TEF_OFF_IRQ_ST) begin
          s_axi_rdata <= {30'h0000_0000, sticky_q};
        end else if (s_axi_araddr == TEF_OFF_IRQ_MSK) begin
          s_axi_rdata <= {30'h0000_0000, mask_q};
        end else begin
          s_axi_rresp <= TEF_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_flag_sets: assert property (@(posedge ref_clk) disable iff (rst)
    match |=> event_q[TEF_BIT_REF])
    else $error("reference flag not set after match");
  a_cap_sets: assert property (@(posedge ref_clk) disable iff (rst)
    cap_evt |=> event_q[TEF_BIT_CAP])
    else $error("capture flag not set after latch");
  a_w1c_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (w1c[TEF_BIT_REF] && !match) |=> !event_q[TEF_BIT_REF])
    else $error("write one did not clear reference flag");
  a_w0_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    (event_q[TEF_BIT_CAP] && !w1c[TEF_BIT_CAP] && !dma_ack) |=> event_q[TEF_BIT_CAP])
    else $error("capture flag lost without clear");
  a_irq_held: assert property (@(posedge ref_clk) disable iff (rst)
    (event_q[TEF_BIT_REF] && cfg.req_en && !cfg.dma_sel) [*2] |-> irq_req)
    else $error("interrupt request dropped while flag set");
  a_ack_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (dma_ack && !match && !cap_evt) |=> event_q == '0)
    else $error("dma acknowledge did not clear flags");
  a_ref_route: assert property (@(posedge ref_clk) disable iff (rst)
    $past(event_q[TEF_BIT_REF] && !cfg.req_en && cfg.edge_sel == TEF_EDGE_OFF)
    |-> !irq_req && !dma_req)
    else $error("request without enable");
  a_cap_dma: assert property (@(posedge ref_clk) disable iff (rst)
    (event_q[TEF_BIT_CAP] && cfg.edge_sel != TEF_EDGE_OFF && cfg.dma_sel) |=> dma_req)
    else $error("capture dma request missing");
  a_match_tick: assert property (@(posedge ref_clk) disable iff (rst)
    (count_q == compare_q && !tick && !event_q[TEF_BIT_REF]) |=> !event_q[TEF_BIT_REF])
    else $error("reference flag set without prescaler tick");
  a_restart_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (match && cfg.restart && !(wr_go && aw_addr_q == TEF_OFF_MODE)) |=> count_q == 32'h0)
    else $error("restart did not clear counter");
  a_edge_off: assert property (@(posedge ref_clk) disable iff (rst)
    cfg.edge_sel == TEF_EDGE_OFF |-> !cap_evt)
    else $error("capture with edge disabled");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rd_go && s_axi_araddr == TEF_OFF_EVENT) |-> s_axi_rdata[31:2] == '0)
    else $error("reserved event bits not zero");

  c_ref_irq: cover property (@(posedge ref_clk) disable iff (rst) irq_req);
  c_dma_ack: cover property (@(posedge ref_clk) disable iff (rst) dma_req ##1 dma_ack);
  c_capture: cover property (@(posedge ref_clk) disable iff (rst) cap_evt);

endmodule : tef_timer

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the timer event and reference block
// Assumes: AXI4-Lite master tasks; dma stand-in tef_far_end
// Notes:   read results are checked by a monitor against a queue of notes
`timescale 1ns/1ps
module tb_top
  import tef_pkg::*;
;
  // ************************************************************
  // signals
  // ************************************************************
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
    logic [1:0]  rsp;
  } tef_note_s;
  logic        ref_clk = 1'b0, rst = 1'b1, tin = 1'b0, ack_en = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic        awr, wr, bvld, arr, rvld, irq_req, dma_req, irq, dma_ack;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rd, seed = 32'h0000_0037;
  logic [1:0]  br, rr;
  logic [3:0]  ack_dly = 4'h0;
  int          failures = 0, tests_run = 0;
  tef_note_s   notes[$];
  logic [1:0]  bnotes[$];

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  tef_timer DUT (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvld),
    .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rvld), .s_axi_rready(rry), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .timer_in(tin), .dma_ack(dma_ack), .irq_req(irq_req),
    .dma_req(dma_req), .irq(irq));

  tef_far_end u_far (.ref_clk(ref_clk), .rst(rst), .ack_en(ack_en), .ack_dly(ack_dly),
    .dma_req(dma_req), .dma_ack(dma_ack));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // mode word with the timer always running
  function automatic logic [31:0] mode_w(logic rs, logic rq, logic [1:0] e, logic [7:0] ps);
    logic [31:0] m;
    m = {16'h0000, ps, 8'h00};
    m[TEF_BIT_ENABLE] = 1'b1;
    m[TEF_BIT_RESTART] = rs;
    m[TEF_BIT_REQ_EN] = rq;
    m[TEF_POS_EDGE +: 2] = e;
    return m;
  endfunction : mode_w

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic pins(input logic ir, input logic dm);
    chk("irq_req", 32'(ir), 32'(irq_req));
    chk("dma_req", 32'(dm), 32'(dma_req));
  endtask : pins

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // address and data offered together, each dropped once taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rs = TEF_RESP_OKAY);
    @(posedge ref_clk);
    bnotes.push_back(rs);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bvld && bry));
    bry <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] ex,
                        input logic [31:0] m = 32'hFFFF_FFFF,
                        input logic [1:0] rs = TEF_RESP_OKAY);
    @(posedge ref_clk);
    notes.push_back('{ex, m, rs});
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rvld && rry));
    rry <= 1'b0;
  endtask : rd_reg

  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // read monitor: oldest note against each returned word
  always @(posedge ref_clk) begin : mon
    tef_note_s n;
    if (rvld && rry) begin
      n = notes.pop_front();
      chk("read data", n.exp & n.msk, rd & n.msk);
      chk("read resp", {30'h0, n.rsp}, {30'h0, rr});
    end
    // write response against the oldest write note
    if (bvld && bry) begin
      chk("write resp", {30'h0, bnotes.pop_front()}, {30'h0, br});
    end
  end

  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    int         c, ps, i;
    logic       dm, rq;
    logic [1:0] e;
    cyc(16);
    rst <= 1'b0;
    rd_reg(TEF_OFF_MODE, {16'h0000, TEF_RST_MODE});
    rd_reg(TEF_OFF_XMODE, {24'h0, TEF_RST_XMODE});
    rd_reg(TEF_OFF_COMPARE, TEF_RST_COMPARE);
    wr_reg(TEF_OFF_EVENT, 32'h0000_00FF);
    rd_reg(TEF_OFF_EVENT, 32'h0);
    rd_reg(8'h20, 32'h0, 32'hFFFF_FFFF, TEF_RESP_SLVERR);
    wr_reg(8'h20, 32'h0, TEF_RESP_SLVERR);
    wr_reg(8'h06, 32'h0, TEF_RESP_SLVERR);
    // reference match for every enable / dma select pair, random compare and prescale
    for (i = 0; i < 4; i++) begin
      rq = i[1];
      dm = i[0];
      c  = 3 + int'(rnd() % 4);
      ps = int'(rnd() % 4);
      wr_reg(TEF_OFF_MODE, 32'h0);
      wr_reg(TEF_OFF_COUNT, 32'h0);
      wr_reg(TEF_OFF_COMPARE, 32'(c));
      wr_reg(TEF_OFF_XMODE, 32'(dm) << TEF_BIT_DMA_SEL);
      wr_reg(TEF_OFF_EVENT, 32'h3);
      wr_reg(TEF_OFF_MODE, mode_w(1'b0, rq, 2'b00, 8'(ps)));
      // flag lands compare+1 ticks after enable, the request one edge later
      cyc((c + 1) * (ps + 1));
      pins(1'b0, 1'b0);
      cyc(1);
      pins(rq & !dm, rq & dm);
      rd_reg(TEF_OFF_EVENT, 32'h2);
      if (dm && rq) begin
        ack_dly <= 4'(rnd() % 8);
        ack_en  <= 1'b1;
        cyc(20);
        pins(1'b0, 1'b0);
        rd_reg(TEF_OFF_EVENT, 32'h0);
        ack_en <= 1'b0;
      end else begin
        wr_reg(TEF_OFF_EVENT, 32'h1);
        rd_reg(TEF_OFF_EVENT, 32'h2);
        pins(rq & !dm, 1'b0);
        wr_reg(TEF_OFF_EVENT, 32'h2);
        cyc(3);
        pins(1'b0, 1'b0);
        rd_reg(TEF_OFF_EVENT, 32'h0);
      end
    end
    // sticky status is masked until the mask opens, read clears it
    chk("irq", 32'h0, 32'(irq));
    wr_reg(TEF_OFF_IRQ_MSK, 32'h2);
    cyc(2);
    chk("irq", 32'h1, 32'(irq));
    rd_reg(TEF_OFF_IRQ_ST, 32'h2, 32'h2);
    cyc(2);
    chk("irq", 32'h0, 32'(irq));
    // restart keeps matching, free run passes the compare once
    wr_reg(TEF_OFF_MODE, 32'h0);
    wr_reg(TEF_OFF_COUNT, 32'h0);
    wr_reg(TEF_OFF_COMPARE, 32'h4);
    wr_reg(TEF_OFF_XMODE, 32'h0);
    wr_reg(TEF_OFF_MODE, mode_w(1'b1, 1'b0, 2'b00, 8'h00));
    cyc(30);
    wr_reg(TEF_OFF_EVENT, 32'h3);
    cyc(20);
    rd_reg(TEF_OFF_EVENT, 32'h2);
    wr_reg(TEF_OFF_MODE, mode_w(1'b0, 1'b0, 2'b00, 8'h00));
    cyc(20);
    wr_reg(TEF_OFF_EVENT, 32'h3);
    cyc(20);
    rd_reg(TEF_OFF_EVENT, 32'h0);
    // capture on each edge setting, interrupt and dma alike
    wr_reg(TEF_OFF_MODE, 32'h0);
    wr_reg(TEF_OFF_COMPARE, 32'hFFFF_FFFF);
    for (i = 0; i < 8; i++) begin
      e  = i[2:1];
      dm = i[0];
      wr_reg(TEF_OFF_XMODE, 32'(dm) << TEF_BIT_DMA_SEL);
      wr_reg(TEF_OFF_MODE, mode_w(1'b0, 1'b0, e, 8'h00));
      wr_reg(TEF_OFF_EVENT, 32'h3);
      tin <= 1'b1;
      cyc(8);
      rd_reg(TEF_OFF_EVENT, 32'(e[0]));
      pins(e[0] & !dm, e[0] & dm);
      wr_reg(TEF_OFF_EVENT, 32'h3);
      tin <= 1'b0;
      cyc(8);
      rd_reg(TEF_OFF_EVENT, 32'(e[1]));
      pins(e[1] & !dm, e[1] & dm);
    end
    cyc(4);
    finish_test();
  end
endmodule : tb_top

// *** verif/tef_far_end.sv ***
// Purpose: dma controller stand-in that answers timer dma requests
// Assumes: ref_clk domain; ack_dly sets how slowly it answers
// Notes:   the interrupt side only listens, so it needs no model
`timescale 1ns/1ps
module tef_far_end (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // bench control
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  // dma handshake
  input  wire logic       dma_req,
  output logic            dma_ack
);
  // ************************************************************
  // acknowledge
  // ************************************************************
  logic [3:0] wait_q;
  logic       busy;
  assign busy = ack_en && dma_req && !dma_ack;
  // one-cycle ack after ack_dly+1 cycles of pending request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_q  <= 4'h0;
      dma_ack <= 1'b0;
    end else if (busy && wait_q == ack_dly) begin
      wait_q  <= 4'h0;
      dma_ack <= 1'b1;
    end else begin
      wait_q  <= busy ? wait_q + 4'h1 : 4'h0;
      dma_ack <= 1'b0;
    end
  end
endmodule : tef_far_end
